// [logic/enhanced_timer.sv]
// Enhanced timer top: APB registers, 10-bit counter, comparators and two pins.
`timescale 1ns/1ps
module enhanced_timer (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timer_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins.
	output logic timer_out_a,
	output logic timer_out_a_oe_n,
	output logic timer_out_b,
	output logic timer_out_b_oe_n
);
	import timer_pkg::*;

	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	logic timer_run_r;
	logic run_prev_r;
	logic [2:0] period_field_r;
	cnt_t chan_a_compare_value_r;
	cnt_t chan_b_compare_value_r;
	logic [2:0] flags_r;
	cnt_t cnt_r;
	cnt_t cnt_nxt;
	phase_t st_r;
	phase_t st_nxt;
	logic [31:0] prdata_r;
	logic [31:0] rd_nxt;
	logic err_nxt;
	logic pready_r;
	logic pslverr_r;
	logic setup;
	logic wr_en;
	logic [1:0] chan_a_mode;
	logic [1:0] chan_b_mode;
	logic [1:0] align_select;
	logic counter_clear_select;
	logic mode_cmp;
	logic mode_tc;
	logic mode_pwm;
	logic centre;
	logic run_on;
	logic run_rise;
	logic counting;
	logic up;
	logic dir_ok;
	cnt_t per_top;
	cnt_t top;
	cnt_t last;
	cnt_t lim;
	logic [CNT_W:0] per_val;
	logic match_a;
	logic match_b;
	logic match_p;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	cnt_t ccr_c [2];
	logic match_c [2];
	logic used_c [2];
	logic [1:0] act_c [2];
	logic lvl_c [2];
	logic inv_c [2];

	// Field decode of the two control registers.
	assign chan_a_mode = ctrl1_r[F_MODE+:2];
	assign chan_b_mode = ctrl2_r[F_MODE+:2];
	assign align_select = ctrl2_r[F_ALIGN+:2];
	assign counter_clear_select = ctrl1_r[F_CLR];

	// Only matched mode pairs run; any mixed pair holds the counter.
	// compare mode decode
	assign mode_cmp = (chan_a_mode == MODE_CMP) && (chan_b_mode == MODE_CMP);
	assign mode_tc = (chan_a_mode == MODE_TC) && (chan_b_mode == MODE_TC);
	assign mode_pwm = (chan_a_mode == MODE_PWM) && (chan_b_mode == MODE_PWM);
	assign centre = mode_pwm && (align_select != ALIGN_EDGE);

	// Run control and its rising edge.
	assign run_on = timer_run_r && (mode_cmp || mode_tc || mode_pwm);
	assign run_rise = timer_run_r && !run_prev_r;
	assign counting = run_on && !run_rise;
	assign up = (st_r != ST_DOWN);

	assign per_top = (period_field_r == RST_PER) ? CNT_MAX
		: cnt_t'(cnt_t'(period_field_r) << PER_SH);
	assign top = counter_clear_select ? chan_a_compare_value_r : per_top;
	assign last = ((top == CNT_MAX) || (top == RST_CCR)) ? top : top - 1'b1;
	assign lim = (mode_pwm && !centre) ? last : top;

	// Centre period is twice the turning point; edge period is last plus one.
	// centre period
	assign per_val = centre ? {top, 1'b0} : {1'b0, last} + 11'h001;

	assign dir_ok = !centre || (align_select == ALIGN_BOTH)
		|| (up ? (align_select == ALIGN_UP) : (align_select == ALIGN_DOWN));

	// Comparators; all matches are suppressed in the restart cycle.
	// In edge PWM with clear-select high the counter wraps one short of A (at A when A is 0 or 1023), so the wrap is A's match.
	// wrap raises A
	assign match_a = counting && dir_ok
		&& ((cnt_r == chan_a_compare_value_r) || (mode_pwm && !centre && counter_clear_select && (cnt_r == lim)));
	assign match_b = counting && dir_ok && (cnt_r == chan_b_compare_value_r);
	assign match_p = counting && !counter_clear_select && (cnt_r == lim);

	// Counter sequencing: edge and compare wrap at the limit, centre turns.
	always_comb begin
		cnt_nxt = cnt_r;
		st_nxt = st_r;
		if (run_rise) begin
			cnt_nxt = RST_CCR;
			st_nxt = ST_UP;
		end else if (!run_on) begin
			st_nxt = ST_IDLE;
		end else if (!centre) begin
			st_nxt = ST_UP;
			cnt_nxt = (cnt_r == lim) ? RST_CCR : cnt_r + 1'b1;
		end else begin
			unique case (st_r)
				ST_DOWN: begin
					cnt_nxt = (cnt_r == RST_CCR) ? RST_CCR : cnt_r - 1'b1;
					if (cnt_r <= 10'h001) begin
						st_nxt = ST_UP;
					end
				end
				default: begin
					st_nxt = ST_UP;
					if (top == RST_CCR) begin
						cnt_nxt = RST_CCR;
					end else if (cnt_r >= top) begin
						st_nxt = ST_DOWN;
						cnt_nxt = cnt_r - 1'b1;
					end else begin
						cnt_nxt = cnt_r + 1'b1;
					end
				end
			endcase
		end
	end

	// Counter and phase registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= RST_CCR;
			st_r <= ST_IDLE;
			run_prev_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			st_r <= st_nxt;
			run_prev_r <= timer_run_r;
		end
	end

	// Bus strobes; writes land at the access edge that samples pready.
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready_r && pwrite;

	// Configuration registers written by software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl1_r <= RST_CTRL;
			ctrl2_r <= RST_CTRL;
			timer_run_r <= 1'b0;
			period_field_r <= RST_PER;
			chan_a_compare_value_r <= RST_CCR;
			chan_b_compare_value_r <= RST_CCR;
		end else if (wr_en) begin
			if (paddr == OFS_CTRL1) begin
				ctrl1_r <= pwdata[7:0];
			end
			if (paddr == OFS_CTRL2) begin
				ctrl2_r <= pwdata[7:0];
			end
			if (paddr == OFS_RUN) begin
				timer_run_r <= pwdata[F_TRUN];
				period_field_r <= pwdata[F_PER+:3];
			end
			if (paddr == OFS_CHAN_A_COMPARE_VALUE) begin
				chan_a_compare_value_r <= pwdata[CNT_W-1:0];
			end
			if (paddr == OFS_CHAN_B_COMPARE_VALUE) begin
				chan_b_compare_value_r <= pwdata[CNT_W-1:0];
			end
		end
	end

	assign flag_set = {match_p, match_b, match_a};
	assign flag_clr = (wr_en && (paddr == OFS_FLAGS)) ? pwdata[2:0] : RST_FLAGS;

	// Sticky flags cleared by writing ones; a match in the clear cycle wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= RST_FLAGS;
		end else begin
			flags_r <= (flags_r & ~flag_clr) | flag_set;
		end
	end

	// Read mux; the direction bit shows the live counting phase.
	always_comb begin
		rd_nxt = 32'h0000_0000;
		err_nxt = 1'b0;
		unique case (paddr)
			OFS_CTRL1: rd_nxt[7:0] = {ctrl1_r[7:2], st_r == ST_DOWN, ctrl1_r[F_CLR]};
			OFS_CTRL2: rd_nxt[7:0] = ctrl2_r;
			OFS_RUN: rd_nxt[3:0] = {period_field_r, timer_run_r};
			OFS_CHAN_A_COMPARE_VALUE: rd_nxt[CNT_W-1:0] = chan_a_compare_value_r;
			OFS_CHAN_B_COMPARE_VALUE: rd_nxt[CNT_W-1:0] = chan_b_compare_value_r;
			OFS_FLAGS: rd_nxt[2:0] = flags_r;
			OFS_COUNT: rd_nxt[CNT_W-1:0] = cnt_r;
			default: err_nxt = 1'b1;
		endcase
	end

	// Answer registered at setup so the access phase has zero wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup && err_nxt;
			if (setup && !pwrite) begin
				prdata_r <= rd_nxt;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// Per-channel settings, channel A in slot 0 and channel B in slot 1.
	assign ccr_c[0] = chan_a_compare_value_r;
	assign ccr_c[1] = chan_b_compare_value_r;
	assign match_c[0] = match_a;
	assign match_c[1] = match_b;
	assign act_c[0] = ctrl1_r[F_ACT+:2];
	assign act_c[1] = ctrl2_r[F_ACT+:2];
	assign lvl_c[0] = ctrl1_r[F_LVL];
	assign lvl_c[1] = ctrl2_r[F_LVL];
	assign inv_c[0] = ctrl1_r[F_INV];
	assign inv_c[1] = ctrl2_r[F_INV];
	assign used_c[0] = mode_cmp || (mode_pwm && !counter_clear_select);
	assign used_c[1] = mode_cmp || mode_pwm;

	pin_ctl_if pio[2] ();

	// One pin unit per channel; a duty at or above the period holds active.
	for (genvar i = 0; i < 2; i++) begin : g_pin
		assign pio[i].cmp = mode_cmp;
		assign pio[i].pwm = mode_pwm;
		assign pio[i].used = used_c[i];
		assign pio[i].action = act_c[i];
		assign pio[i].level = lvl_c[i];
		assign pio[i].invert = inv_c[i];
		assign pio[i].run_rise = run_rise;
		assign pio[i].match = match_c[i];
		assign pio[i].active = ({1'b0, ccr_c[i]} >= per_val) || (cnt_r < ccr_c[i]);
		pin_unit u_pin (
			.pclk(pclk),
			.presetn(presetn),
			.io(pio[i])
		);
	end

	assign timer_out_a = pio[0].pin;
	assign timer_out_a_oe_n = pio[0].oe_n;
	assign timer_out_b = pio[1].pin;
	assign timer_out_b_oe_n = pio[1].oe_n;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_cmp_high_a;
		counting && mode_cmp && match_a && (act_c[0] == ACT_HIGH) && !inv_c[0]
			##1 (!run_rise && !inv_c[0]);
	endsequence

	sequence s_run_start_a;
		run_rise && mode_cmp && !inv_c[0] ##1 !match_a && !run_rise && !inv_c[0];
	endsequence

	property p_cmp_counts;
		(mode_cmp && counting && (cnt_r != lim)) |=> (cnt_r == $past(cnt_r) + 1'b1);
	endproperty
	a_cmp_counts: assert property (p_cmp_counts) else $error("counter did not step");

	property p_period_clear;
		(mode_cmp && counting && !counter_clear_select && (cnt_r == top))
			|=> (cnt_r == RST_CCR) && flags_r[FLG_P];
	endproperty
	a_period_clear: assert property (p_period_clear) else $error("period clear missed");

	property p_no_period_flag;
		$rose(flags_r[FLG_P]) |-> !$past(counter_clear_select);
	endproperty
	a_no_period_flag: assert property (p_no_period_flag) else $error("period flag leaked");

	property p_cmp_high;
		s_cmp_high_a |=> timer_out_a;
	endproperty
	a_cmp_high: assert property (p_cmp_high) else $error("pin A not driven high");

	property p_run_level;
		s_run_start_a |=> (timer_out_a == $past(lvl_c[0], 2));
	endproperty
	a_run_level: assert property (p_run_level) else $error("pin A not at start level");

	property p_tc_pins_free;
		mode_tc |=> timer_out_a_oe_n && timer_out_b_oe_n;
	endproperty
	a_tc_pins_free: assert property (p_tc_pins_free) else $error("pin driven in t/c");

	property p_full_duty;
		(mode_pwm && ({1'b0, chan_b_compare_value_r} >= per_val) && (act_c[1] == PACT_PWM)
			&& lvl_c[1] && !inv_c[1]) [*2] |=> timer_out_b;
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("full duty not held");

	property p_flag_b;
		match_b |=> flags_r[FLG_B];
	endproperty
	a_flag_b: assert property (p_flag_b) else $error("channel B flag missed");

	property p_wrap_1023;
		(mode_pwm && !centre && counter_clear_select && (chan_a_compare_value_r == CNT_MAX) && counting
			&& (cnt_r == 10'h3FE)) |=> (cnt_r == CNT_MAX);
	endproperty
	a_wrap_1023: assert property (p_wrap_1023) else $error("1023 period wrong");

	property p_centre_turn;
		(centre && counting && up && (top != RST_CCR) && (cnt_r == top))
			|=> (st_r == ST_DOWN) && (cnt_r == top - 1'b1);
	endproperty
	a_centre_turn: assert property (p_centre_turn) else $error("no turn at top");
endmodule : enhanced_timer

// [logic/pin_ctl_if.sv]
// Interface carrying one pin channel's controls and its driven pin.
`timescale 1ns/1ps
interface pin_ctl_if;
	logic cmp;
	logic pwm;
	logic used;
	logic [1:0] action;
	logic level;
	logic invert;
	logic run_rise;
	logic match;
	logic active;
	logic pin;
	logic oe_n;
	modport ctl (output cmp, pwm, used, action, level, invert, run_rise, match, active,
		input pin, oe_n);
	modport unit (input cmp, pwm, used, action, level, invert, run_rise, match, active,
		output pin, oe_n);
endinterface : pin_ctl_if

// [logic/pin_unit.sv]
// Output pin logic of one timer channel for compare and PWM modes.
`timescale 1ns/1ps
module pin_unit (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Channel controls and pin.
	pin_ctl_if.unit io
);
	import timer_pkg::*;

	logic level_r;
	logic drive;
	logic pin_nxt;
	logic pin_r;
	logic oe_n_r;

	// Compare-mode pin level; the run edge wins over a match in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 1'b0;
		end else if (io.run_rise) begin
			level_r <= io.level;
		end else if (io.cmp && io.match) begin
			unique case (io.action)
				ACT_LOW: level_r <= 1'b0;
				ACT_HIGH: level_r <= 1'b1;
				ACT_TOGGLE: level_r <= ~level_r;
				default: level_r <= level_r;
			endcase
		end
	end

	always_comb begin
		drive = (io.action == PACT_PWM) ? io.active : (io.action == PACT_ACTIVE);
		if (io.cmp) begin
			pin_nxt = level_r ^ io.invert;
		end else if (io.pwm) begin
			pin_nxt = (drive ? io.level : ~io.level) ^ io.invert;
		end else begin
			pin_nxt = 1'b0;
		end
	end

	// Pin and enable are registered so the top drives its pins from flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			pin_r <= io.used ? pin_nxt : 1'b0;
			oe_n_r <= ~io.used;
		end
	end

	assign io.pin = pin_r;
	assign io.oe_n = oe_n_r;
endmodule : pin_unit

// [logic/timer_pkg.sv]
// Constants, field layout, register map and phase type of the enhanced timer.
// What this block does
// - Both mode fields at 00 select compare match output mode.
// - Clear-select low: period match or overflow clears counter; A and period flags.
// - Clear-select high: channel A match clears counter; period flag never raised.
// - In compare mode a pin changes only on its own channel match.
// - Pin action field sets high, low, toggles, or leaves pin unchanged on match.
// - A rising edge of the run bit returns each pin to its initial level.
// - Mode fields 11 give timer/counter mode: compare behaviour, pins left unused.
// - PWM, clear-select high: A sets period, B sets duty on pin B only.
// - PWM, clear-select low: edge period is field times 128, zero gives 1024.
// - A duty value at or above the period gives 100% duty.
// - Edge mode starts all pulses at counter zero; centre mode counts up/down.
// - PWM raises separate flags for channel A, channel B and period matches.
// - PWM: level bit picks active level, action forces or enables, invert flips.
// - Edge PWM with A as period: period equals A, except 1023 gives 1024.
// - Centre PWM with period field: 256 times field, zero gives 2046; duty 2A-1.
// - Alignment 00 edge; 01 up-count, 10 down-count, 11 both-direction matches.
// - Clear-select 0 picks the period match, 1 picks the channel A match.
package timer_pkg;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 10;
	typedef logic [CNT_W-1:0] cnt_t;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL2 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RUN = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CHAN_A_COMPARE_VALUE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CHAN_B_COMPARE_VALUE = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h18;
	localparam int F_MODE = 6;
	localparam int F_ACT = 4;
	localparam int F_LVL = 3;
	localparam int F_INV = 2;
	localparam int F_DIR = 1;
	localparam int F_CLR = 0;
	localparam int F_ALIGN = 0;
	localparam int F_TRUN = 0;
	localparam int F_PER = 1;
	localparam int FLG_A = 0;
	localparam int FLG_B = 1;
	localparam int FLG_P = 2;
	localparam int PER_SH = 7;
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TC = 2'h3;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] PACT_ACTIVE = 2'h1;
	localparam logic [1:0] PACT_PWM = 2'h2;
	localparam logic [1:0] ALIGN_EDGE = 2'h0;
	localparam logic [1:0] ALIGN_UP = 2'h1;
	localparam logic [1:0] ALIGN_DOWN = 2'h2;
	localparam logic [1:0] ALIGN_BOTH = 2'h3;
	localparam cnt_t CNT_MAX = 10'h3FF;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [2:0] RST_PER = 3'h0;
	localparam cnt_t RST_CCR = 10'h000;
	localparam logic [2:0] RST_FLAGS = 3'h0;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_UP = 2'h1, ST_DOWN = 2'h3} phase_t;
endpackage : timer_pkg

// [tb/enhanced_timer_tb.sv]
// Self-checking testbench of the enhanced timer: registers, compare, counter and PWM modes.
`timescale 1ns/1ps
module enhanced_timer_tb;
	import timer_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} reg_row_t;
	typedef struct {logic [7:0] c1; logic [7:0] c2; logic [7:0] run; cnt_t ca; cnt_t cb;
		int per; int ha; int hb; logic [2:0] fl;} pwm_row_t;
	localparam logic [7:0] OFS_NONE = 8'h1C;
	localparam int LIMIT = 40000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic timer_out_a, timer_out_a_oe_n, timer_out_b, timer_out_b_oe_n, load_a, load_b;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int ha, hb;
	// Register rows: optional write, then the read-back value and error flag expected.
	reg_row_t regs[9] = '{
		'{1'b0, OFS_CTRL1, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_RUN, 32'h0, 32'h0, 1'b0},
		'{1'b0, OFS_CHAN_A_COMPARE_VALUE, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_FLAGS, 32'h0, 32'h0, 1'b0},
		'{1'b0, OFS_COUNT, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_CTRL2, 32'h00FF, 32'h00FF, 1'b0},
		'{1'b1, OFS_CHAN_B_COMPARE_VALUE, 32'h07FF, 32'h03FF, 1'b0}, '{1'b1, OFS_COUNT, 32'h0055, 32'h0, 1'b0},
		'{1'b1, OFS_NONE, 32'h00FF, 32'h0, 1'b1}};
	// PWM rows: setup, one period in cycles, expected high cycles per pin and flags.
	pwm_row_t pwm[8] = '{
		'{8'hA8, 8'hA8, 8'h03, 10'h020, 10'h0C8, 128, 32, 128, 3'h5},
		'{8'hAC, 8'h98, 8'h03, 10'h020, 10'h040, 128, 96, 128, 3'h7},
		'{8'hA8, 8'hA8, 8'h01, 10'h100, 10'h3FF, 1024, 256, 1023, 3'h7},
		'{8'hA9, 8'hA8, 8'h01, 10'h032, 10'h00A, 50, 0, 10, 3'h3},
		'{8'hA9, 8'hA8, 8'h01, 10'h3FF, 10'h200, 1024, 0, 512, 3'h3},
		'{8'hA9, 8'hAB, 8'h01, 10'h014, 10'h005, 40, 0, 9, 3'h3},
		'{8'hA8, 8'hA9, 8'h03, 10'h010, 10'h12C, 256, 31, 256, 3'h5},
		'{8'hA8, 8'hAA, 8'h03, 10'h010, 10'h028, 256, 31, 79, 3'h7}};

	enhanced_timer i_enhanced_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_out_a(timer_out_a),
		.timer_out_a_oe_n(timer_out_a_oe_n), .timer_out_b(timer_out_b),
		.timer_out_b_oe_n(timer_out_b_oe_n));
	pin_load i_pin_load_a (.pin(timer_out_a), .oe_n(timer_out_a_oe_n), .level(load_a));
	pin_load i_pin_load_b (.pin(timer_out_b), .oe_n(timer_out_b_oe_n), .level(load_b));

	// Free-running 50 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Cuts a hang short; the ceiling is well above the few thousand cycles the tests need.
	initial begin
		forever begin
			@(posedge pclk);
			cycles++;
			if (cycles == LIMIT) begin
				fail_count++;
				summarize();
			end
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk

	// Counts the cycles in which each load sees a high level.
	task automatic highs(input int per);
		ha = 0;
		hb = 0;
		repeat (per) begin
			@(posedge pclk);
			ha += int'(load_a);
			hb += int'(load_b);
		end
	endtask : highs

	task automatic summarize();
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (5) @(posedge pclk);
		check(32'({timer_out_a, timer_out_a_oe_n, timer_out_b, timer_out_b_oe_n}), 32'h0005);
		presetn <= 1'b1;
		foreach (regs[i]) begin
			if (regs[i].w) begin
				apb(1'b1, regs[i].a, regs[i].d);
				check(32'(er), 32'(regs[i].e));
			end
			rdchk(regs[i].a, regs[i].r);
			check(32'(er), 32'(regs[i].e));
		end
		// Compare mode, period top 128: pin A set high at 5, pin B toggles at 10.
		// nonzero channel A
		wr(OFS_CTRL1, 32'h0020);
		wr(OFS_CTRL2, 32'h0038);
		wr(OFS_CHAN_A_COMPARE_VALUE, 32'h0005);
		wr(OFS_CHAN_B_COMPARE_VALUE, 32'h000A);
		wr(OFS_RUN, 32'h0003);
		repeat (3) @(posedge pclk);
		check(32'({timer_out_a, timer_out_a_oe_n, timer_out_b, timer_out_b_oe_n}), 32'h0002);
		repeat (20) @(posedge pclk);
		check(32'({timer_out_a, timer_out_b}), 32'h0002);
		rdchk(OFS_FLAGS, 32'h0003);
		repeat (130) @(posedge pclk);
		rdchk(OFS_FLAGS, 32'h0007);
		check(32'({timer_out_a, timer_out_b}), 32'h0003);
		wr(OFS_RUN, 32'h0002);
		wr(OFS_FLAGS, 32'h0007);
		rdchk(OFS_FLAGS, 32'h0000);
		wr(OFS_RUN, 32'h0003);
		repeat (3) @(posedge pclk);
		check(32'({timer_out_a, timer_out_b}), 32'h0001);
		// Clear on channel A at 20; the period flag must stay low.
		wr(OFS_RUN, 32'h0002);
		wr(OFS_FLAGS, 32'h0007);
		wr(OFS_CTRL1, 32'h0021);
		wr(OFS_CHAN_A_COMPARE_VALUE, 32'h0014);
		wr(OFS_RUN, 32'h0003);
		repeat (300) @(posedge pclk);
		rdchk(OFS_FLAGS, 32'h0003);
		apb(1'b0, OFS_COUNT, 32'h0);
		check(32'(rd <= 32'h0014), 32'h0001);
		// Timer/counter mode: flags as compare mode, both pins released.
		wr(OFS_RUN, 32'h0002);
		wr(OFS_FLAGS, 32'h0007);
		wr(OFS_CTRL1, 32'h00C0);
		wr(OFS_CTRL2, 32'h00C0);
		wr(OFS_CHAN_A_COMPARE_VALUE, 32'h0005);
		wr(OFS_RUN, 32'h0003);
		repeat (40) @(posedge pclk);
		check(32'({timer_out_a_oe_n, timer_out_b_oe_n, load_a, load_b}), 32'h000C);
		rdchk(OFS_FLAGS, 32'h0003);
		// A mixed pair of channel modes leaves the counter at rest.
		wr(OFS_RUN, 32'h0002);
		wr(OFS_CTRL2, 32'h0000);
		wr(OFS_RUN, 32'h0003);
		repeat (10) @(posedge pclk);
		rdchk(OFS_COUNT, 32'h0000);
		// PWM rows, each set up with the timer stopped.
		foreach (pwm[i]) begin
			wr(OFS_RUN, 32'h0000);
			wr(OFS_FLAGS, 32'h0007);
			wr(OFS_CTRL1, 32'(pwm[i].c1));
			wr(OFS_CTRL2, 32'(pwm[i].c2));
			wr(OFS_CHAN_A_COMPARE_VALUE, 32'(pwm[i].ca));
			wr(OFS_CHAN_B_COMPARE_VALUE, 32'(pwm[i].cb));
			wr(OFS_RUN, 32'(pwm[i].run));
			repeat (pwm[i].per + 4) @(posedge pclk);
			highs(pwm[i].per);
			check(32'(ha), 32'(pwm[i].ha));
			check(32'(hb), 32'(pwm[i].hb));
			rdchk(OFS_FLAGS, 32'(pwm[i].fl));
		end
		summarize();
	end
endmodule : enhanced_timer_tb

// [tb/pin_load.sv]
// Load model that stands on each timer output pin.
`timescale 1ns/1ps
module pin_load (
	// Pin and its active-low drive enable.
	input wire logic pin,
	input wire logic oe_n,
	// Level seen by the load.
	output logic level
);
	// A weak pull-down sets the line while the timer leaves it undriven, so no stale level survives.
	assign level = oe_n ? 1'b0 : pin;
endmodule : pin_load
